// ===== core/sledp_top.sv
// How it works
// - two-bit source picks off, power, charger, manual
// - outputs are plain digital on/off levels
// - source patterns only in ON or SLEEP; the code also shows them while power_seq_fail is set
// - auto-program complete lights output one
// - auto-program error lights output two
// - auto-program indication overrides every source
// - auto-program indication held until reset
// - sequence failure: four 1s pulses, 1:1
// - supply low: 250ms on, 1:3, continuous
// - ON constant; SLEEP 250ms on, 1:7
// - priority: failure, supply low, ON, SLEEP
// - charge complete constant; charging 1s, 1:2
// - manual pattern: off, constant, continuous, sequence
// - manual on time and ratio selections
// - manual sequence 1,2,4,7 pulses, then off
//
// Added by the designer: the APB register port.
`timescale 1ns/1ns
module sledp_top #(
    parameter int TICK_CYCLES = sledp_pkg::TICK_CYCLES
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [17:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // power state and supply status
    input wire logic state_on,
    input wire logic state_sleep,
    input wire logic power_seq_fail,
    input wire logic supply_low,
    // charger status
    input wire logic charge_complete,
    input wire logic charge_active,
    // one-time-programmable auto-program status
    input wire logic otp_prog_done,
    input wire logic otp_prog_error,
    // indicator outputs
    output logic status_output_one,
    output logic status_output_two,
    // failure sequence emitted, power state may go to OFF
    output logic seq_fail_shown
);

    // ------------------------------------------------------------
    // pattern selection
    // ------------------------------------------------------------
    function automatic logic [7:0] make_desc(input logic [1:0] mode, input logic [1:0] len,
                                             input logic [1:0] dur, input logic [1:0] ratio);
        make_desc = {mode, len, dur, ratio};
    endfunction : make_desc

    function automatic logic [7:0] power_desc(input logic fail, input logic low,
                                              input logic on, input logic sleep);
        if (fail) begin
            power_desc = make_desc(sledp_pkg::MODE_SEQ, sledp_pkg::LEN_4, sledp_pkg::DUR_1S,
                                   sledp_pkg::RATIO_1_1);
        end else if (low) begin
            power_desc = make_desc(sledp_pkg::MODE_CONT, sledp_pkg::ZERO2, sledp_pkg::DUR_250MS,
                                   sledp_pkg::RATIO_1_3);
        end else if (on) begin
            power_desc = make_desc(sledp_pkg::MODE_CONST, sledp_pkg::ZERO2, sledp_pkg::ZERO2,
                                   sledp_pkg::ZERO2);
        end else if (sleep) begin
            power_desc = make_desc(sledp_pkg::MODE_CONT, sledp_pkg::ZERO2, sledp_pkg::DUR_250MS,
                                   sledp_pkg::RATIO_1_7);
        end else begin
            power_desc = '0;
        end
    endfunction : power_desc

    function automatic logic [7:0] charger_desc(input logic done, input logic active);
        if (done) begin
            charger_desc = make_desc(sledp_pkg::MODE_CONST, sledp_pkg::ZERO2, sledp_pkg::ZERO2,
                                     sledp_pkg::ZERO2);
        end else if (active) begin
            charger_desc = make_desc(sledp_pkg::MODE_CONT, sledp_pkg::ZERO2, sledp_pkg::DUR_1S,
                                     sledp_pkg::RATIO_1_2);
        end else begin
            charger_desc = '0;
        end
    endfunction : charger_desc

    function automatic logic [7:0] select_desc(input logic [15:0] cfg, input logic [7:0] pwr,
                                               input logic [7:0] chg, input logic allowed);
        logic [1:0] src;
        src = cfg[sledp_pkg::SRC_LSB +: 2];
        select_desc = '0;
        if (allowed) begin
            case (src)
                sledp_pkg::SRC_OFF: select_desc = '0;
                sledp_pkg::SRC_POWER: select_desc = pwr;
                sledp_pkg::SRC_CHARGER: select_desc = chg;
                sledp_pkg::SRC_MANUAL: select_desc = make_desc(cfg[sledp_pkg::MODE_LSB +: 2],
                                                               cfg[sledp_pkg::LEN_LSB +: 2],
                                                               cfg[sledp_pkg::DUR_LSB +: 2],
                                                               cfg[sledp_pkg::RATIO_LSB +: 2]);
                default: select_desc = '0;
            endcase
        end
    endfunction : select_desc

    function automatic logic is_src(input logic [15:0] cfg, input logic [1:0] code);
        is_src = (cfg[sledp_pkg::SRC_LSB +: 2] == code);
    endfunction : is_src

    // ------------------------------------------------------------
    // apb decode
    // ------------------------------------------------------------
    logic [15:0] cfg_one_q;
    logic [15:0] cfg_two_q;
    logic [15:0] status_word;
    logic [15:0] word_idx;
    logic hit_one;
    logic hit_two;
    logic hit_status;
    logic mapped;
    logic setup;
    logic access_wr;
    logic [31:0] rdata_d;
    logic [31:0] prdata_q;
    logic pslverr_q;

    assign word_idx = paddr[sledp_pkg::ADDR_W-1:sledp_pkg::IDX_LSB];
    assign hit_one = (word_idx == sledp_pkg::IDX_OUT_ONE_CFG);
    assign hit_two = (word_idx == sledp_pkg::IDX_OUT_TWO_CFG);
    assign hit_status = (word_idx == sledp_pkg::IDX_STATUS);
    // misaligned addresses count as unmapped
    assign mapped = (hit_one || hit_two || hit_status) && (paddr[1:0] == 2'h0);
    assign setup = psel && !penable;
    assign access_wr = psel && penable && pwrite && mapped;
    assign pready = 1'b1;
    assign prdata = prdata_q;
    assign pslverr = pslverr_q;

    always_comb begin
        rdata_d = '0;
        if (hit_one) begin
            rdata_d = {16'h0000, cfg_one_q};
        end else if (hit_two) begin
            rdata_d = {16'h0000, cfg_two_q};
        end else if (hit_status) begin
            rdata_d = {16'h0000, status_word};
        end
    end

    // read data and error are captured in setup so the access phase has no wait state
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_q <= '0;
            pslverr_q <= 1'b0;
        end else if (setup) begin
            prdata_q <= (mapped && !pwrite) ? rdata_d : 32'h0000_0000;
            pslverr_q <= !mapped;
        end
    end

    // ------------------------------------------------------------
    // configuration registers
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg_one_q <= sledp_pkg::CFG_RESET;
        end else if (access_wr && hit_one) begin
            cfg_one_q <= pwdata[15:0] & sledp_pkg::CFG_WMASK;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cfg_two_q <= sledp_pkg::CFG_RESET;
        end else if (access_wr && hit_two) begin
            cfg_two_q <= pwdata[15:0] & sledp_pkg::CFG_WMASK;
        end
    end

    // ------------------------------------------------------------
    // auto-program indication, sticky until reset
    // ------------------------------------------------------------
    logic otp_done_q;
    logic otp_err_q;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            otp_done_q <= 1'b0;
            otp_err_q <= 1'b0;
        end else begin
            otp_done_q <= otp_done_q || otp_prog_done;
            otp_err_q <= otp_err_q || otp_prog_error;
        end
    end

    // ------------------------------------------------------------
    // pattern engines
    // ------------------------------------------------------------
    logic allowed;
    logic [7:0] pwr_desc;
    logic [7:0] chg_desc;
    logic [7:0] desc_one;
    logic [7:0] desc_two;
    logic level_one;
    logic level_two;
    logic done_one;
    logic done_two;
    logic fail_one_q;
    logic fail_two_q;

    // failure pattern must still run while the power state is leaving ON
    assign allowed = state_on || state_sleep || power_seq_fail;
    assign pwr_desc = power_desc(power_seq_fail, supply_low, state_on, state_sleep);
    assign chg_desc = charger_desc(charge_complete, charge_active);
    assign desc_one = select_desc(cfg_one_q, pwr_desc, chg_desc, allowed);
    assign desc_two = select_desc(cfg_two_q, pwr_desc, chg_desc, allowed);

    sledp_channel #(
        .TICK_CYCLES(TICK_CYCLES)
    ) u_chan_one (
        .pclk(pclk),
        .presetn(presetn),
        .desc(desc_one),
        .level_q(level_one),
        .seq_done_q(done_one)
    );

    sledp_channel #(
        .TICK_CYCLES(TICK_CYCLES)
    ) u_chan_two (
        .pclk(pclk),
        .presetn(presetn),
        .desc(desc_two),
        .level_q(level_two),
        .seq_done_q(done_two)
    );

    // remember which channel was running the failure pattern when its sequence ends
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fail_one_q <= 1'b0;
            fail_two_q <= 1'b0;
        end else begin
            fail_one_q <= power_seq_fail && allowed && is_src(cfg_one_q, sledp_pkg::SRC_POWER);
            fail_two_q <= power_seq_fail && allowed && is_src(cfg_two_q, sledp_pkg::SRC_POWER);
        end
    end

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status_output_one <= 1'b0;
            status_output_two <= 1'b0;
            seq_fail_shown <= 1'b0;
        end else begin
            status_output_one <= otp_done_q || level_one;
            status_output_two <= otp_err_q || level_two;
            seq_fail_shown <= (done_one && fail_one_q) || (done_two && fail_two_q);
        end
    end

    assign status_word = {12'h000, otp_err_q, otp_done_q, status_output_two, status_output_one};

endmodule : sledp_top

// ===== core/sledp_pkg.sv
package sledp_pkg;

    // ------------------------------------------------------------
    // register map
    // ------------------------------------------------------------
    // printed offsets are word indices; byte address is four times the index
    localparam logic [15:0] IDX_OUT_ONE_CFG = 16'h404C;
    localparam logic [15:0] IDX_OUT_TWO_CFG = 16'h404D;
    localparam logic [15:0] IDX_STATUS = 16'h404E;
    localparam int ADDR_W = 18;
    localparam int IDX_LSB = 2;
    localparam int REG_W = 16;
    localparam logic [15:0] CFG_RESET = 16'hC026;
    localparam logic [15:0] CFG_WMASK = 16'hC33F;

    // ------------------------------------------------------------
    // field positions
    // ------------------------------------------------------------
    localparam int SRC_LSB = 14;
    localparam int MODE_LSB = 8;
    localparam int LEN_LSB = 4;
    localparam int DUR_LSB = 2;
    localparam int RATIO_LSB = 0;
    localparam int ST_OUT_ONE = 0;
    localparam int ST_OUT_TWO = 1;
    localparam int ST_OTP_DONE = 2;
    localparam int ST_OTP_ERR = 3;

    // ------------------------------------------------------------
    // codes
    // ------------------------------------------------------------
    localparam logic [1:0] SRC_OFF = 2'h0;
    localparam logic [1:0] SRC_POWER = 2'h1;
    localparam logic [1:0] SRC_CHARGER = 2'h2;
    localparam logic [1:0] SRC_MANUAL = 2'h3;
    localparam logic [1:0] MODE_OFF = 2'h0;
    localparam logic [1:0] MODE_CONST = 2'h1;
    localparam logic [1:0] MODE_CONT = 2'h2;
    localparam logic [1:0] MODE_SEQ = 2'h3;
    localparam logic [1:0] DUR_1S = 2'h0;
    localparam logic [1:0] DUR_250MS = 2'h1;
    localparam logic [1:0] RATIO_1_1 = 2'h0;
    localparam logic [1:0] RATIO_1_2 = 2'h1;
    localparam logic [1:0] RATIO_1_3 = 2'h2;
    localparam logic [1:0] RATIO_1_7 = 2'h3;
    localparam logic [1:0] LEN_4 = 2'h2;
    localparam logic [1:0] ZERO2 = 2'h0;

    // ------------------------------------------------------------
    // timing: one tick is the shortest on time
    // ------------------------------------------------------------
    localparam int CLK_MHZ = 125;
    localparam int TICK_TIME_US = 62500;
    localparam int TICK_CYCLES = TICK_TIME_US * CLK_MHZ;
    localparam logic [4:0] TICKS_1S = 5'h10;
    localparam logic [4:0] TICKS_250MS = 5'h04;
    localparam logic [4:0] TICKS_125MS = 5'h02;
    localparam logic [4:0] TICKS_62MS = 5'h01;
    localparam logic [2:0] MULT_1 = 3'h1;
    localparam logic [2:0] MULT_2 = 3'h2;
    localparam logic [2:0] MULT_3 = 3'h3;
    localparam logic [2:0] MULT_7 = 3'h7;
    localparam logic [2:0] PULSES_1 = 3'h1;
    localparam logic [2:0] PULSES_2 = 3'h2;
    localparam logic [2:0] PULSES_4 = 3'h4;
    localparam logic [2:0] PULSES_7 = 3'h7;

    // pattern descriptor {mode, len, dur, ratio}
    localparam int DESC_W = 8;

endpackage : sledp_pkg

// ===== core/sledp_channel.sv
`timescale 1ns/1ns
module sledp_channel #(
    parameter int TICK_CYCLES = sledp_pkg::TICK_CYCLES
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // pattern descriptor {mode, len, dur, ratio}
    input wire logic [7:0] desc,
    // indicator level and end of a pulse sequence
    output logic level_q,
    output logic seq_done_q
);

    localparam int PRE_W = (TICK_CYCLES > 1) ? $clog2(TICK_CYCLES) : 1;
    localparam logic [PRE_W-1:0] PRE_LAST = PRE_W'(TICK_CYCLES - 1);

    typedef enum logic [3:0] {
        ST_IDLE = 4'h1,
        ST_ON = 4'h2,
        ST_OFF = 4'h4,
        ST_HOLD = 4'h8
    } sledp_state_t;

    // ------------------------------------------------------------
    // field decoding
    // ------------------------------------------------------------
    function automatic logic [4:0] on_ticks(input logic [1:0] dur);
        case (dur)
            2'h0: on_ticks = sledp_pkg::TICKS_1S;
            2'h1: on_ticks = sledp_pkg::TICKS_250MS;
            2'h2: on_ticks = sledp_pkg::TICKS_125MS;
            default: on_ticks = sledp_pkg::TICKS_62MS;
        endcase
    endfunction : on_ticks

    function automatic logic [2:0] off_mult(input logic [1:0] ratio);
        case (ratio)
            sledp_pkg::RATIO_1_1: off_mult = sledp_pkg::MULT_1;
            sledp_pkg::RATIO_1_2: off_mult = sledp_pkg::MULT_2;
            sledp_pkg::RATIO_1_3: off_mult = sledp_pkg::MULT_3;
            default: off_mult = sledp_pkg::MULT_7;
        endcase
    endfunction : off_mult

    function automatic logic [2:0] pulses(input logic [1:0] len);
        case (len)
            2'h0: pulses = sledp_pkg::PULSES_1;
            2'h1: pulses = sledp_pkg::PULSES_2;
            2'h2: pulses = sledp_pkg::PULSES_4;
            default: pulses = sledp_pkg::PULSES_7;
        endcase
    endfunction : pulses

    logic [1:0] mode;
    logic [4:0] on_len;
    logic [7:0] off_len;
    logic [2:0] seq_len;
    logic [7:0] desc_q;
    logic restart;
    logic [PRE_W-1:0] pre_q;
    logic tick;
    logic [7:0] ticks_q;
    logic [2:0] count_q;
    sledp_state_t state_q;
    sledp_state_t start_state;

    assign mode = desc[7:6];
    assign on_len = on_ticks(desc[3:2]);
    assign off_len = 8'(on_len * off_mult(desc[1:0]));
    assign seq_len = pulses(desc[5:4]);
    assign restart = (desc != desc_q);
    assign tick = (pre_q == PRE_LAST);

    always_comb begin
        case (mode)
            sledp_pkg::MODE_OFF: start_state = ST_IDLE;
            sledp_pkg::MODE_CONST: start_state = ST_HOLD;
            default: start_state = ST_ON;
        endcase
    end

    // ------------------------------------------------------------
    // tick prescaler, restarted with the pattern
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            desc_q <= '0;
        end else begin
            desc_q <= desc;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pre_q <= '0;
        end else if (restart || tick) begin
            pre_q <= '0;
        end else begin
            pre_q <= pre_q + 1'b1;
        end
    end

    // ------------------------------------------------------------
    // on/off phase engine
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= ST_IDLE;
            ticks_q <= '0;
            count_q <= '0;
            seq_done_q <= 1'b0;
        end else begin
            seq_done_q <= 1'b0;
            if (restart) begin
                state_q <= start_state;
                ticks_q <= '0;
                count_q <= '0;
            end else if (tick) begin
                case (state_q)
                    ST_ON: begin
                        if (ticks_q == 8'(on_len - 1'b1)) begin
                            state_q <= ST_OFF;
                            ticks_q <= '0;
                        end else begin
                            ticks_q <= ticks_q + 1'b1;
                        end
                    end
                    ST_OFF: begin
                        if (ticks_q == off_len - 1'b1) begin
                            ticks_q <= '0;
                            // finished sequence stays dark until the pattern changes
                            if (mode == sledp_pkg::MODE_SEQ && count_q == seq_len - 1'b1) begin
                                state_q <= ST_IDLE;
                                seq_done_q <= 1'b1;
                            end else begin
                                state_q <= ST_ON;
                                count_q <= count_q + 1'b1;
                            end
                        end else begin
                            ticks_q <= ticks_q + 1'b1;
                        end
                    end
                    default: begin
                        state_q <= state_q;
                    end
                endcase
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            level_q <= 1'b0;
        end else begin
            level_q <= (state_q == ST_ON) || (state_q == ST_HOLD);
        end
    end

endmodule : sledp_channel

// ===== dv/sledp_led_model.sv
`timescale 1ns/1ns
module sledp_led_model (
    // clock and lamp drive
    input wire logic pclk,
    input wire logic level,
    input wire logic clr,
    // totals since last clear
    output int on_cnt,
    output int rises
);
    logic last_q;

    // lamp lit only while driven high, no analogue level exists
    always_ff @(posedge pclk) begin
        last_q <= level;
        on_cnt <= clr ? 0 : on_cnt + int'(level === 1'b1);
        rises <= clr ? 0 : rises + int'(level === 1'b1 && last_q !== 1'b1);
    end
endmodule : sledp_led_model

// ===== dv/sledp_top_asserts.sv
`timescale 1ns/1ns
module sledp_top_asserts #(
    parameter int TICK_CYCLES = 4
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb
    input wire logic psel,
    input wire logic penable,
    input wire logic [17:0] paddr,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // status and indicators
    input wire logic state_on,
    input wire logic state_sleep,
    input wire logic power_seq_fail,
    input wire logic otp_prog_done,
    input wire logic otp_prog_error,
    input wire logic status_output_one,
    input wire logic status_output_two,
    input wire logic seq_fail_shown
);
    logic otp_seen_q;
    logic quiet;
    logic mapped;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) otp_seen_q <= 1'b0;
        else if (otp_prog_done || otp_prog_error) otp_seen_q <= 1'b1;
    end
    assign quiet = !state_on && !state_sleep && !power_seq_fail && !otp_prog_done && !otp_prog_error;
    assign mapped = paddr == 18'h10130 || paddr == 18'h10134 || paddr == 18'h10138;

    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    otp_done_a: assert property (otp_prog_done |-> ##2 status_output_one [*8])
        else $error("output one not held after program done");
    otp_err_a: assert property (otp_prog_error |-> ##2 status_output_two [*8])
        else $error("output two not held after program error");
    quiet_off_a: assert property (!otp_seen_q && quiet && $past(quiet) && $past(quiet, 2) && $past(quiet, 3)
        |-> !status_output_one && !status_output_two)
        else $error("indicator lit outside on or sleep");
    fail_pulse_a: assert property (seq_fail_shown |=> !seq_fail_shown [*8])
        else $error("failure done flag longer than one cycle");
    bad_addr_a: assert property (psel && !penable && !mapped |=> pslverr)
        else $error("no error on unmapped address");
    good_addr_a: assert property (psel && !penable && mapped |=> !pslverr)
        else $error("error on mapped address");
    rdata_upper_a: assert property (psel && penable |-> prdata[31:16] == 16'h0000)
        else $error("read data upper half not zero");
    ready_a: assert property (psel && penable |-> pready)
        else $error("access phase without ready");
endmodule : sledp_top_asserts

bind sledp_top sledp_top_asserts #(.TICK_CYCLES(TICK_CYCLES)) u_chk (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .paddr(paddr),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .state_on(state_on),
    .state_sleep(state_sleep), .power_seq_fail(power_seq_fail), .otp_prog_done(otp_prog_done),
    .otp_prog_error(otp_prog_error), .status_output_one(status_output_one),
    .status_output_two(status_output_two), .seq_fail_shown(seq_fail_shown));

// ===== dv/sledp_top_tb_top.sv
`timescale 1ns/1ns
module sledp_top_tb_top;
    localparam int TC = 4;
    localparam logic [15:0] A1 = sledp_pkg::IDX_OUT_ONE_CFG;
    localparam logic [15:0] A2 = sledp_pkg::IDX_OUT_TWO_CFG;
    localparam logic [15:0] AS = sledp_pkg::IDX_STATUS;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, clr = 1'b0;
    logic [17:0] paddr = 18'h00000;
    logic [31:0] pwdata = 32'h0, prdata, rd;
    logic pready, pslverr, err, o1, o2, fshown;
    logic st_on = 1'b0, st_sl = 1'b0, sfail = 1'b0, slow = 1'b0, cdone = 1'b0, cact = 1'b0;
    logic otp_d = 1'b0, otp_e = 1'b0;
    int mismatches = 0, compares = 0, fails = 0, f0, on1, on2, r1, r2;
    int ont[4] = '{sledp_pkg::TICKS_1S, sledp_pkg::TICKS_250MS, sledp_pkg::TICKS_125MS, sledp_pkg::TICKS_62MS};
    int mul[4] = '{2, 3, 4, 8};
    int seqn[4] = '{1, 2, 4, 7};

    always #4 pclk = ~pclk;
    always @(posedge pclk) if (fshown === 1'b1) fails <= fails + 1;

    sledp_top #(.TICK_CYCLES(TC)) i_sledp_top (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .state_on(st_on), .state_sleep(st_sl),
        .power_seq_fail(sfail), .supply_low(slow), .charge_complete(cdone), .charge_active(cact),
        .otp_prog_done(otp_d), .otp_prog_error(otp_e), .status_output_one(o1),
        .status_output_two(o2), .seq_fail_shown(fshown));
    sledp_led_model i_led_one (.pclk(pclk), .level(o1), .clr(clr), .on_cnt(on1), .rises(r1));
    sledp_led_model i_led_two (.pclk(pclk), .level(o2), .clr(clr), .on_cnt(on2), .rises(r2));

    function automatic logic [15:0] cfg(input logic [1:0] s, m, l, d, r);
        return {s, 4'h0, m, 2'h0, l, d, r};
    endfunction : cfg

    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            mismatches++;
            $display("MISMATCH %s expected %h seen %h", n, e, g);
        end
    endtask : chk

    // one idle cycle before each setup so psel is never driven twice in a step
    task automatic apb(input logic w, input logic [15:0] idx, input logic [15:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= {idx, 2'h0};
        pwdata <= {16'h0000, d};
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    task automatic rdchk(input string n, input logic [15:0] idx, input logic [15:0] e);
        apb(1'b0, idx, 16'h0000);
        chk(n, {16'h0000, e}, rd);
    endtask : rdchk

    // clears both lamp models once a change has crossed the three output flops, then counts n samples
    task automatic span(input int n);
        repeat (2) @(posedge pclk);
        clr <= 1'b1;
        @(posedge pclk);
        clr <= 1'b0;
        repeat (n + 1) @(posedge pclk);
    endtask : span

    task automatic close_out;
        $display("compares %0d mismatches %0d", compares, mismatches);
        if (mismatches == 0 && compares > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask : close_out

    initial begin
        repeat (20000) @(posedge pclk);
        mismatches++;
        $display("watchdog expired");
        close_out;
    end

    initial begin
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        rdchk("cfg one", A1, sledp_pkg::CFG_RESET);
        rdchk("cfg two", A2, sledp_pkg::CFG_RESET);
        apb(1'b1, A2, 16'hFFFF);
        rdchk("cfg mask", A2, sledp_pkg::CFG_WMASK);
        apb(1'b1, AS, 16'hFFFF);
        rdchk("status ro", AS, 16'h0000);
        apb(1'b0, 16'h4050, 16'h0000);
        chk("unmapped err", 32'h1, {31'h0, err});
        $display("test registers done");
        st_on <= 1'b1;
        apb(1'b1, A1, cfg(2'h3, 2'h0, 2'h0, 2'h0, 2'h0));
        span(40);
        chk("manual off", 32'h0, on1);
        apb(1'b1, A1, cfg(2'h3, 2'h1, 2'h0, 2'h0, 2'h0));
        span(40);
        chk("manual const", 32'd40, on1);
        for (int d = 0; d < 4; d++) begin
            for (int r = 0; r < 4; r++) begin
                apb(1'b1, A1, cfg(2'h3, 2'h2, 2'h0, d[1:0], r[1:0]));
                span(ont[d] * TC * mul[r]);
                chk("cont on time", ont[d] * TC, on1);
            end
        end
        apb(1'b1, A1, cfg(2'h3, 2'h0, 2'h0, 2'h0, 2'h0));
        for (int l = 0; l < 4; l++) begin
            span(0);
            apb(1'b1, A1, cfg(2'h3, 2'h3, l[1:0], 2'h3, 2'h0));
            repeat (81) @(posedge pclk);
            chk("seq pulses", seqn[l], r1);
            chk("seq on time", seqn[l] * TC, on1);
            chk("seq ends off", 32'h0, {31'h0, o1});
        end
        $display("test manual done");
        apb(1'b1, A1, cfg(2'h2, 2'h0, 2'h0, 2'h0, 2'h0));
        apb(1'b1, A2, cfg(2'h1, 2'h0, 2'h0, 2'h0, 2'h0));
        cdone <= 1'b1;
        span(50);
        chk("charge done", 32'd50, on1);
        chk("on state", 32'd50, on2);
        cdone <= 1'b0;
        cact <= 1'b1;
        st_on <= 1'b0;
        st_sl <= 1'b1;
        span(384);
        chk("charging", 32'd128, on1);
        chk("sleep", 32'd48, on2);
        slow <= 1'b1;
        span(384);
        chk("supply low", 32'd96, on2);
        st_sl <= 1'b0;
        slow <= 1'b0;
        span(40);
        chk("not on one", 32'h0, on1);
        chk("not on two", 32'h0, on2);
        f0 = fails;
        sfail <= 1'b1;
        span(532);
        chk("fail pulses", 32'd4, r2);
        chk("fail on time", 32'd256, on2);
        chk("fail done", 32'd1, fails - f0);
        sfail <= 1'b0;
        apb(1'b1, A1, cfg(2'h0, 2'h1, 2'h0, 2'h0, 2'h0));
        apb(1'b1, A2, cfg(2'h0, 2'h1, 2'h0, 2'h0, 2'h0));
        st_on <= 1'b1;
        cdone <= 1'b1;
        span(30);
        chk("source off", 32'h0, on1);
        $display("test sources done");
        otp_d <= 1'b1;
        @(posedge pclk);
        otp_d <= 1'b0;
        otp_e <= 1'b1;
        @(posedge pclk);
        otp_e <= 1'b0;
        span(30);
        chk("otp done lamp", 32'd30, on1);
        chk("otp error lamp", 32'd30, on2);
        rdchk("status flags", AS, 16'h000F);
        presetn <= 1'b0;
        repeat (2) @(posedge pclk);
        chk("reset clears", 32'h0, {30'h0, o1, o2});
        presetn <= 1'b1;
        rdchk("cfg after reset", A1, sledp_pkg::CFG_RESET);
        chk("dark after reset", 32'h0, {30'h0, o1, o2});
        $display("test program status done");
        close_out;
    end
endmodule : sledp_top_tb_top
